// >>> logic/fpu_concurrency_timing.sv
`timescale 1ns/100ps
// What this block does
// - The concurrent variant takes the next instruction in the tail.
// - Overlap gained is the lesser of remaining tail count and next head.
// - Elapsed time is the sum of overall times less the overlap.
// - The non-concurrent variant never overlaps instructions.
// - A store with a dynamic k-factor takes 14 more cycles.
// - A host data register source saves 5 cycles, a destination 2.
// - Moves with no tail go idle straight after their head.
// - A register conflict with the running instruction cuts overlap.
// - Address time adds to the head except for moves to memory.
// - A store answers null with both bits, then transfer, then null.
// - The non-concurrent variant adds 5, 3, 1 or 194 nulls by format.
// - The concurrent variant adds nulls only for integer and packed.
// - A host data register operand drops one read or write cycle.
// - The constant load takes its source from the constant ROM.
module fpu_concurrency_timing
  import fpu_timing_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_concurrent,
  input wire logic i_issue,
  input wire instr_t i_instr,
  input wire logic i_resp_read,
  input wire logic i_xfer_done,
  output logic o_accept,
  output logic o_busy,
  output logic o_in_tail,
  output logic [CW-1:0] o_cycle_count,
  output resp_t o_resp,
  output logic o_src_rom,
  output logic [2:0] o_rd_words,
  output logic [2:0] o_wr_words,
  output logic [SW-1:0] o_sum_overall,
  output logic [SW-1:0] o_overlap,
  output logic [SW-1:0] o_elapsed
);

  // ****************************************
  // Timing arithmetic
  // ****************************************
  function automatic logic [CW-1:0] eff_head(input instr_t x);
    logic [CW:0] h;
    h = {1'b0, x.head};
    if (x.opclass != OPC_TO_MEM) begin
      h = h + {1'b0, x.ea_time};
    end else if (x.dyn_k) begin
      h = h + {1'b0, DYN_K_EXTRA};
    end
    if (x.src_dreg) begin
      h = (h > {1'b0, SRC_DREG_SAVE}) ? h - {1'b0, SRC_DREG_SAVE}
                                      : {1'b0, CYC_ONE};
    end
    // Saturate rather than wrap on absurd descriptors
    if (h[CW]) begin
      return '1;
    end
    return (h[CW-1:0] == '0) ? CYC_ONE : h[CW-1:0];
  endfunction

  function automatic logic [CW-1:0] eff_tail(input instr_t x);
    if (x.no_tail) begin
      return '0;
    end
    if (x.dst_dreg) begin
      return (x.tail > DST_DREG_SAVE) ? x.tail - DST_DREG_SAVE : '0;
    end
    return x.tail;
  endfunction

  function automatic logic [CW-1:0] min_cyc(input logic [CW-1:0] a,
                                            input logic [CW-1:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [2:0] words(input fmt_t f);
    case (f)
      FMT_INT, FMT_SGL: return WORDS_1;
      FMT_DBL: return WORDS_2;
      FMT_EXT, FMT_PKD: return WORDS_3;
      default: return WORDS_0;
    endcase
  endfunction

  function automatic logic [7:0] poll_count(input fmt_t f, input logic conc);
    case (f)
      FMT_INT: return POLL_INT;
      FMT_PKD: return POLL_PKD;
      FMT_SGL, FMT_DBL: return conc ? POLL_NONE : POLL_SGL_DBL;
      FMT_EXT: return conc ? POLL_NONE : POLL_EXT;
      default: return POLL_NONE;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  state_t s;
  state_t next_s;
  logic conflict;
  logic can_take;
  logic take;
  logic [CW-1:0] new_head;
  logic [CW-1:0] gain;

  always_comb begin
    next_s = s;
    next_s.accept = 1'b0;
    new_head = eff_head(i_instr);
    conflict = (i_instr.source_fp_register ==
                s.cur.destination_fp_register) ||
               (i_instr.destination_fp_register ==
                s.cur.destination_fp_register);
    // Pending response sequence blocks issue so primitives never interleave
    can_take = (s.rsp == RS_NONE) &&
               ((s.phase == PH_IDLE) ||
                ((s.phase == PH_TAIL) && i_concurrent &&
                 !conflict));
    take = i_issue && !s.accept && can_take;
    gain = (s.phase == PH_TAIL) ? min_cyc(s.cnt, new_head) : '0;

    case (s.phase)
      PH_HEAD: begin
        if (s.cnt <= CYC_ONE) begin
          if (eff_tail(s.cur) == '0) begin
            next_s.phase = PH_IDLE;
            next_s.cnt = '0;
          end else begin
            next_s.phase = PH_TAIL;
            next_s.cnt = eff_tail(s.cur);
          end
        end else begin
          next_s.cnt = s.cnt - CYC_ONE;
        end
      end
      PH_TAIL: begin
        if (s.cnt <= CYC_ONE) begin
          next_s.phase = PH_IDLE;
          next_s.cnt = '0;
        end else begin
          next_s.cnt = s.cnt - CYC_ONE;
        end
      end
      default: begin
        next_s.cnt = '0;
      end
    endcase

    if (take) begin
      next_s.accept = 1'b1;
      next_s.cur = i_instr;
      next_s.phase = PH_HEAD;
      next_s.cnt = new_head;
      next_s.rom_sel = i_instr.rom_const;
      next_s.rd_words = WORDS_0;
      next_s.wr_words = WORDS_0;
      if (i_instr.opclass == OPC_TO_MEM) begin
        next_s.wr_words = words(i_instr.fmt) -
                          {2'h0, i_instr.dst_dreg};
        next_s.rsp = RS_START;
        next_s.polls = poll_count(i_instr.fmt, i_concurrent);
        next_s.resp = '{1'b1, PRIM_NULL, 1'b1, 1'b1};
      end else if (i_instr.arith) begin
        next_s.rd_words = (i_instr.fmt == FMT_FPREG) ? WORDS_0 :
          words(i_instr.fmt) - {2'h0, i_instr.src_dreg};
      end
      next_s.sum_overall = s.sum_overall + SW'(new_head) +
                           SW'(eff_tail(i_instr));
      next_s.overlap = s.overlap + SW'(gain);
    end

    // Response primitive sequence for moves to memory
    case (s.rsp)
      RS_START, RS_POLL: begin
        if (i_resp_read) begin
          if (s.polls == POLL_NONE) begin
            next_s.rsp = RS_XFER;
            next_s.resp = '{1'b1, PRIM_EVAL_XFER, 1'b0, 1'b0};
          end else begin
            next_s.rsp = RS_POLL;
            next_s.polls = s.polls - 8'h01;
          end
        end
      end
      RS_XFER: begin
        if (i_resp_read && !s.xfer_wait) begin
          next_s.xfer_wait = 1'b1;
          next_s.resp.valid = 1'b0;
        end
        if (s.xfer_wait && i_xfer_done) begin
          next_s.xfer_wait = 1'b0;
          next_s.rsp = RS_DONE;
          next_s.resp = '{1'b1, PRIM_NULL, 1'b0, 1'b0};
        end
      end
      RS_DONE: begin
        if (i_resp_read) begin
          next_s.rsp = RS_NONE;
          next_s.resp = '0;
        end
      end
      default: begin
        next_s.xfer_wait = 1'b0;
      end
    endcase

    next_s.elapsed = next_s.sum_overall - next_s.overlap;
    // Busy kept in a flop so the output has no gate after the register
    next_s.busy = (next_s.phase != PH_IDLE) || (next_s.rsp != RS_NONE);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      s <= '0;
      s.phase <= PH_IDLE;
      s.rsp <= RS_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign o_accept = s.accept;
  assign o_busy = s.busy;
  assign o_in_tail = s.phase[2];
  assign o_cycle_count = s.cnt;
  assign o_resp = s.resp;
  assign o_src_rom = s.rom_sel;
  assign o_rd_words = s.rd_words;
  assign o_wr_words = s.wr_words;
  assign o_sum_overall = s.sum_overall;
  assign o_overlap = s.overlap;
  assign o_elapsed = s.elapsed;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  idle_issue_taken_a: assert property (i_issue && !s.accept &&
    s.phase == PH_IDLE && s.rsp == RS_NONE |=> o_accept)
    else $error("Idle issue not accepted");
  no_overlap_noncon_a: assert property (o_accept &&
    !$past(i_concurrent) |-> $past(s.phase) == PH_IDLE &&
    s.overlap == $past(s.overlap))
    else $error("Non-concurrent overlap seen");
  overlap_is_min_a: assert property (o_accept &&
    $past(s.phase) == PH_TAIL |-> s.overlap - $past(s.overlap) ==
    SW'(min_cyc($past(s.cnt), s.cnt)))
    else $error("Overlap not the lesser value");
  elapsed_balance_a: assert property (##1 s.elapsed ==
    s.sum_overall - s.overlap)
    else $error("Elapsed out of balance");
  head_countdown_a: assert property (s.phase == PH_HEAD &&
    s.cnt > CYC_ONE |=> s.phase == PH_HEAD && s.cnt == $past(s.cnt) - 1)
    else $error("Head counter stalled");
  no_tail_idle_a: assert property (s.phase == PH_HEAD &&
    s.cur.no_tail && s.cnt == CYC_ONE |=> s.phase == PH_IDLE)
    else $error("Tail entered by no-tail move");
  dyn_k_extra_a: assert property (o_accept && s.cur.opclass == OPC_TO_MEM &&
    s.cur.dyn_k && !s.cur.src_dreg && s.cur.head < 12'h7f0 |->
    s.cnt == s.cur.head + DYN_K_EXTRA)
    else $error("Dynamic k-factor cycles wrong");
  ea_excluded_a: assert property (o_accept && s.cur.opclass == OPC_TO_MEM &&
    !s.cur.dyn_k && !s.cur.src_dreg && s.cur.head != '0 |->
    s.cnt == s.cur.head)
    else $error("Address time added to store head");
  conflict_held_a: assert property (i_issue && s.phase == PH_TAIL &&
    conflict |=> !o_accept)
    else $error("Conflicting issue overlapped");
  first_prim_a: assert property (o_accept &&
    s.cur.opclass == OPC_TO_MEM |-> o_resp.valid &&
    o_resp.prim == PRIM_NULL && o_resp.repeat_request_bit &&
    o_resp.interrupt_permit_bit)
    else $error("Store did not start with null");
  ext_polls_a: assert property (o_accept && s.cur.opclass == OPC_TO_MEM &&
    s.cur.fmt == FMT_EXT |-> s.polls ==
    ($past(i_concurrent) ? POLL_NONE : POLL_EXT))
    else $error("Extended poll count wrong");
  dreg_read_drop_a: assert property (o_accept && s.cur.arith &&
    s.cur.opclass != OPC_TO_MEM && s.cur.src_dreg &&
    s.cur.fmt == FMT_INT |-> o_rd_words == WORDS_0)
    else $error("Data register read not dropped");

  overlap_seen_c: cover property (o_accept && $past(s.phase) == PH_TAIL);
  store_done_c: cover property (s.rsp == RS_DONE && i_resp_read);
  conflict_wait_c: cover property (i_issue && s.phase == PH_TAIL && conflict);

endmodule

// >>> logic/fpu_timing_pkg.sv
package fpu_timing_pkg;

  localparam int CW = 12;
  localparam int SW = 24;

  localparam logic [2:0] OPC_TO_MEM = 3'h3;
  localparam logic [CW-1:0] DYN_K_EXTRA = 12'h00e;
  localparam logic [CW-1:0] SRC_DREG_SAVE = 12'h005;
  localparam logic [CW-1:0] DST_DREG_SAVE = 12'h002;
  localparam logic [CW-1:0] CYC_ONE = 12'h001;

  localparam logic [7:0] POLL_INT = 8'h05;
  localparam logic [7:0] POLL_SGL_DBL = 8'h03;
  localparam logic [7:0] POLL_EXT = 8'h01;
  localparam logic [7:0] POLL_PKD = 8'hc2;
  localparam logic [7:0] POLL_NONE = 8'h00;

  localparam logic [2:0] WORDS_0 = 3'h0;
  localparam logic [2:0] WORDS_1 = 3'h1;
  localparam logic [2:0] WORDS_2 = 3'h2;
  localparam logic [2:0] WORDS_3 = 3'h3;

  typedef enum logic [2:0] {
    FMT_INT = 3'h0,
    FMT_SGL = 3'h1,
    FMT_DBL = 3'h2,
    FMT_EXT = 3'h3,
    FMT_PKD = 3'h4,
    FMT_FPREG = 3'h5
  } fmt_t;

  typedef struct packed {
    logic [2:0] opclass;
    logic arith;
    logic rom_const;
    logic no_tail;
    fmt_t fmt;
    logic dyn_k;
    logic src_dreg;
    logic dst_dreg;
    logic [2:0] source_fp_register;
    logic [2:0] destination_fp_register;
    logic [CW-1:0] head;
    logic [CW-1:0] tail;
    logic [CW-1:0] ea_time;
  } instr_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_HEAD = 3'b010,
    PH_TAIL = 3'b100
  } phase_t;

  typedef enum logic [4:0] {
    RS_NONE = 5'b00001,
    RS_START = 5'b00010,
    RS_POLL = 5'b00100,
    RS_XFER = 5'b01000,
    RS_DONE = 5'b10000
  } rsp_state_t;

  typedef enum logic [1:0] {
    PRIM_NULL = 2'h0,
    PRIM_EVAL_XFER = 2'h1
  } prim_t;

  typedef struct packed {
    logic valid;
    prim_t prim;
    logic repeat_request_bit;
    logic interrupt_permit_bit;
  } resp_t;

  typedef struct packed {
    phase_t phase;
    logic [CW-1:0] cnt;
    instr_t cur;
    logic accept;
    rsp_state_t rsp;
    logic xfer_wait;
    logic [7:0] polls;
    resp_t resp;
    logic rom_sel;
    logic [2:0] rd_words;
    logic [2:0] wr_words;
    logic [SW-1:0] sum_overall;
    logic [SW-1:0] overlap;
    logic [SW-1:0] elapsed;
    logic busy;
  } state_t;

endpackage

// >>> testbench/fpu_host_model.sv
`timescale 1ns/100ps
// ************
// Host poller
// ************
module fpu_host_model
  import fpu_timing_pkg::*;
(
  input wire logic i_sys_clk,
  input wire resp_t i_resp,
  output logic o_resp_read,
  output logic o_xfer_done
);
  initial begin
    o_resp_read = 1'b0;
    o_xfer_done = 1'b0;
  end
  // Slow host: gap idle cycles after each access
  task automatic pulse(input int gap, input bit x);
    @(negedge i_sys_clk);
    if (x) o_xfer_done = 1'b1;
    else o_resp_read = 1'b1;
    @(negedge i_sys_clk);
    o_resp_read = 1'b0;
    o_xfer_done = 1'b0;
    repeat (gap) @(negedge i_sys_clk);
  endtask
  task automatic store(input int gap, output int extra, output bit ok);
    extra = 0;
    ok = (i_resp === resp_t'{1'b1, PRIM_NULL, 1'b1, 1'b1});
    // Bounded so a stuck device cannot hang the host
    while (ok && i_resp.prim === PRIM_NULL && extra < 400) begin
      pulse(gap, 1'b0);
      if (i_resp.prim === PRIM_NULL) begin
        extra++;
        ok = (i_resp === resp_t'{1'b1, PRIM_NULL, 1'b1, 1'b1});
      end
    end
    ok = ok && i_resp.valid && i_resp.prim === PRIM_EVAL_XFER;
    pulse(gap, 1'b0);
    pulse(gap, 1'b1);
    ok = ok && i_resp.valid && i_resp.prim === PRIM_NULL
      && i_resp.repeat_request_bit === 1'b0;
    pulse(gap, 1'b0);
  endtask
endmodule

// >>> testbench/fpu_concurrency_timing_tb.sv
`timescale 1ns/100ps
module fpu_concurrency_timing_tb
  import fpu_timing_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_concurrent = 1'b0;
  logic i_issue = 1'b0;
  instr_t i_instr = '0;
  logic rd, xd, o_accept, o_busy, o_in_tail, o_src_rom;
  logic [CW-1:0] o_cycle_count;
  resp_t o_resp;
  logic [2:0] o_rd_words, o_wr_words;
  logic [SW-1:0] o_sum_overall, o_overlap, o_elapsed;
  int bad_count = 0;
  int n_compared = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  fpu_concurrency_timing u_fpu_concurrency_timing (.i_sys_clk, .i_rstn,
    .i_concurrent, .i_issue, .i_instr, .i_resp_read(rd), .i_xfer_done(xd),
    .o_accept, .o_busy, .o_in_tail, .o_cycle_count, .o_resp, .o_src_rom,
    .o_rd_words, .o_wr_words, .o_sum_overall, .o_overlap, .o_elapsed);
  fpu_host_model u_fpu_host_model (.i_sys_clk, .i_resp(o_resp),
    .o_resp_read(rd), .o_xfer_done(xd));
  // ***********
  // Helpers
  // ***********
  task automatic chk(input logic [SW-1:0] got, input logic [SW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic instr_t mk(input logic [2:0] oc, input fmt_t f,
    input logic [5:0] fl, input int h, t, e, input logic [2:0] s, d);
    mk = '0;
    mk.opclass = oc;
    mk.fmt = f;
    {mk.arith, mk.rom_const, mk.no_tail, mk.dyn_k, mk.src_dreg,
      mk.dst_dreg} = fl;
    mk.head = CW'(h);
    mk.tail = CW'(t);
    mk.ea_time = CW'(e);
    mk.source_fp_register = s;
    mk.destination_fp_register = d;
  endfunction
  task automatic rst(input logic con);
    @(negedge i_sys_clk);
    i_rstn = 1'b0;
    i_concurrent = con;
    repeat (10) @(negedge i_sys_clk);
    i_rstn = 1'b1;
  endtask
  task automatic iss(input instr_t x);
    int k;
    @(negedge i_sys_clk);
    i_issue = 1'b1;
    i_instr = x;
    @(negedge i_sys_clk);
    for (k = 0; k < 500 && o_accept !== 1'b1; k++) @(negedge i_sys_clk);
    chk(o_accept, 1'b1);
    i_issue = 1'b0;
  endtask
  task automatic wait_tail(input int exp);
    int k;
    for (k = 0; k < 500 && o_in_tail !== 1'b1; k++) @(negedge i_sys_clk);
    chk(o_cycle_count, exp);
  endtask
  task automatic wait_idle(output logic seen);
    int k;
    seen = 1'b0;
    for (k = 0; k < 3000 && o_busy !== 1'b0; k++) begin
      seen = seen | o_in_tail;
      @(negedge i_sys_clk);
    end
    chk(o_busy, 1'b0);
  endtask
  // ***********
  // Scenarios
  // ***********
  task automatic t_overlap(input logic con, input logic cf);
    logic s;
    int ov;
    ov = (con && !cf) ? 4 : 0;
    rst(con);
    iss(mk(3'h0, FMT_DBL, 6'h20, 4, 10, 2, 3'h1, 3'h2));
    chk(o_cycle_count, 6);
    wait_tail(10);
    iss(mk(3'h0, FMT_DBL, 6'h20, 3, 2, 1, cf ? 3'h2 : 3'h3, 3'h4));
    wait_idle(s);
    chk(o_overlap, SW'(ov));
    chk(o_sum_overall, 22);
    chk(o_elapsed, SW'(22 - ov));
    $display("test overlap con=%0d conflict=%0d done", con, cf);
  endtask
  task automatic t_adjust();
    logic s;
    rst(1'b1);
    iss(mk(3'h0, FMT_INT, 6'h22, 10, 9, 2, 3'h1, 3'h2));
    chk(o_cycle_count, 7);
    chk(o_rd_words, 3'h0);
    // Source saving lands on the head; the tail keeps its full length
    wait_tail(9);
    wait_idle(s);
    iss(mk(3'h0, FMT_DBL, 6'h20, 10, 0, 2, 3'h1, 3'h2));
    chk(o_rd_words, 3'h2);
    chk(o_cycle_count, 12);
    wait_idle(s);
    iss(mk(3'h0, FMT_EXT, 6'h10, 5, 0, 0, 3'h0, 3'h3));
    chk(o_src_rom, 1'b1);
    wait_idle(s);
    iss(mk(3'h0, FMT_EXT, 6'h28, 5, 9, 0, 3'h0, 3'h3));
    chk(o_src_rom, 1'b0);
    wait_idle(s);
    chk(s, 1'b0);
    $display("test adjust done");
  endtask
  task automatic t_store();
    fmt_t fm[10] = '{FMT_INT, FMT_SGL, FMT_DBL, FMT_EXT, FMT_INT,
      FMT_SGL, FMT_DBL, FMT_EXT, FMT_PKD, FMT_INT};
    int pe[10] = '{5, 3, 3, 1, 5, 0, 0, 0, 194, 5};
    int wd[10] = '{1, 1, 2, 3, 1, 1, 2, 3, 3, 0};
    int ex;
    bit ok;
    rst(1'b0);
    for (int i = 0; i < 10; i++) begin
      i_concurrent = (i > 3);
      iss(mk(OPC_TO_MEM, fm[i], {3'h0, i == 8, 1'b0, i == 9},
        20, 0, 7, 3'h1, 3'h0));
      chk(o_cycle_count, (i == 8) ? 34 : 20);
      chk(o_wr_words, wd[i][2:0]);
      u_fpu_host_model.store(i % 2, ex, ok);
      chk(ok, 1'b1);
      chk(ex, pe[i]);
    end
    $display("test store done");
  endtask
  // ***********
  // Run
  // ***********
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Tests need some thousand cycles; allow forty times that
  initial begin
    #1000000;
    bad_count++;
    final_report();
  end
  initial begin
    t_overlap(1'b1, 1'b0);
    t_overlap(1'b0, 1'b0);
    t_overlap(1'b1, 1'b1);
    t_adjust();
    t_store();
    final_report();
  end
endmodule
